//--- verilog/flow_baud_channel.sv
// async channel flow control, clock quarter, baud divider and timer
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Function
// - cts low or xon enables transmitter
// - ignore-cts runs transmitter, xon/xoff still gates
// - cts high stops transmitter by default
// - rts high at shadow level 28
// - rts low again when shadow empty
// - shadow moves to user fifo while user fifo has room
// - auto rts low while transmitting
// - force bit lets software set rts
// - drop bit discards received xon/xoff
// - flow features only in async mode
// - quarter bit divides core and timer clock
// - enhanced divisor forms two stages
// - timer quarter only with master clock
// - timer period factor times value plus one
// - standard divide by n plus one times two
// - enhanced divide n plus one times 2^m
// - timer clock follows transmit or crystal
module flow_baud_channel import flow_baud_pkg::*; #(
	parameter int RES_SLOW = 32768,
	parameter int RES_FAST = 512
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic ctsN,
	output logic rtsN,
	input wire logic txBusy,
	input wire logic txCharDone,
	output logic txEnable,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	output logic rxEnable,
	output logic loopTest,
	output logic coreTick,
	output logic timerTick,
	output logic baudTick,
	output logic timerExpired
);
	// software registers
	logic [7:0] mode;
	logic [7:0] timerSetting;
	logic [7:0] rxFifoControl;
	logic [7:0] cfgFour;
	logic [7:0] cfgZero;
	logic [7:0] baudLow;
	logic [BAUD_HI_W-1:0] baudHigh;
	logic [7:0] xonChar;
	logic [7:0] xoffChar;
	// decoded controls
	logic asyncMode;
	logic inband;
	logic ignoreCts;
	logic flowLine;
	logic forceLine;
	logic quarter;
	logic masterClock;
	// transmit gating
	logic xonState;
	logic boundary;
	logic next_txEnable;
	// receive path
	logic isFlow;
	logic dropFlow;
	logic rxTake;
	logic shadowPush;
	logic moveNow;
	logic userPop;
	logic [7:0] shadowHead;
	logic [7:0] userHead;
	logic [FIFO_AW:0] shadowCount;
	logic [FIFO_AW:0] userCount;
	logic shadowEmpty;
	logic shadowFull;
	logic userEmpty;
	logic userFull;
	logic overflow;
	// request line
	rts_mode_e rtsMode;
	logic next_rtsN;
	// clocks and timer
	logic [1:0] quarterCnt;
	logic [TIMER_W-1:0] timerCount;
	logic [TIMER_W-1:0] target;
	logic timerRun;
	logic timerHit;
	logic timerDone;
	logic statusRead;

	// timer length in timer clocks
	function automatic logic [TIMER_W-1:0] timerTarget(input logic res,
			input logic [TIMER_VALUE_W-1:0] value);
		logic [TIMER_W-1:0] factor;
		factor = res ? TIMER_W'(RES_FAST) : TIMER_W'(RES_SLOW);
		return TIMER_W'(factor * ({16'h0000, value} + 21'h000001));
	endfunction

	// register writes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= REG_RESET;
			timerSetting <= REG_RESET;
			rxFifoControl <= REG_RESET;
			cfgFour <= REG_RESET;
			cfgZero <= REG_RESET;
			baudLow <= REG_RESET;
			baudHigh <= '0;
			xonChar <= XON_RESET;
			xoffChar <= XOFF_RESET;
		end else if (regWrite) begin
			case (regAddr)
				ADDR_MODE: mode <= regWrData;
				ADDR_TIMER: timerSetting <= regWrData;
				ADDR_RXFC: rxFifoControl <= regWrData;
				ADDR_CFG4: cfgFour <= regWrData;
				ADDR_CFG0: cfgZero <= regWrData;
				ADDR_BAUD_LO: baudLow <= regWrData;
				ADDR_BAUD_HI: baudHigh <= regWrData[BAUD_HI_W-1:0];
				ADDR_XON: xonChar <= regWrData;
				ADDR_XOFF: xoffChar <= regWrData;
				default: ;
			endcase
		end
	end

	// flow bits only count in async mode
	assign asyncMode = (cfgZero[CFG0_PROTO_LSB +: PROTO_W] == PROTO_ASYNC);
	assign inband = asyncMode && mode[MODE_INBAND];
	assign ignoreCts = mode[MODE_IGNORE_CTS];
	assign flowLine = mode[MODE_FLOW_LINE];
	assign forceLine = mode[MODE_FORCE];
	assign quarter = cfgFour[CFG4_QUARTER];
	assign masterClock = cfgZero[CFG0_MCE];
	assign rxEnable = mode[MODE_RX_ACTIVE];
	assign loopTest = mode[MODE_LOOP];

	// in-band state follows received xon/xoff
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			xonState <= 1'b1;
		end else if (!inband) begin
			xonState <= 1'b1;
		end else if (rxTake && rxByte == xonChar) begin
			xonState <= 1'b1;
		end else if (rxTake && rxByte == xoffChar) begin
			xonState <= 1'b0;
		end
	end

	// transmitter permission from cts and in-band state
	always_comb begin
		if (!asyncMode) begin
			next_txEnable = 1'b1;
		end else if (!inband) begin
			next_txEnable = ignoreCts || !ctsN;
		end else if (ignoreCts) begin
			next_txEnable = xonState;
		end else begin
			next_txEnable = !ctsN || xonState;
		end
	end

	// permission only changes between characters
	assign boundary = !txBusy || txCharDone;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			txEnable <= 1'b0;
		end else if (boundary) begin
			txEnable <= next_txEnable;
		end
	end

	// received byte classification
	assign rxTake = rxValid && rxEnable;
	assign isFlow = (rxByte == xonChar) || (rxByte == xoffChar);
	assign dropFlow = inband && rxFifoControl[RFC_DROP];
	assign shadowPush = rxTake && !(dropFlow && isFlow) && !shadowFull;
	assign moveNow = !shadowEmpty && !userFull;
	assign userPop = regRead && regAddr == ADDR_RXDATA && !userEmpty;

	// shadow stage behind the receiver
	sync_fifo shadowFifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.push(shadowPush),
		.wrData(rxByte),
		.pop(moveNow),
		.rdData(shadowHead),
		.count(shadowCount),
		.empty(shadowEmpty),
		.full(shadowFull)
	);

	// software-visible receive fifo
	sync_fifo userFifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.push(moveNow),
		.wrData(shadowHead),
		.pop(userPop),
		.rdData(userHead),
		.count(userCount),
		.empty(userEmpty),
		.full(userFull)
	);

	// who owns the request line
	always_comb begin
		if (!asyncMode) begin
			rtsMode = RTS_TX_AUTO;
		end else if (forceLine) begin
			rtsMode = RTS_FORCE;
		end else if (flowLine) begin
			rtsMode = RTS_RX_FLOW;
		end else begin
			rtsMode = RTS_TX_AUTO;
		end
	end

	// request line level
	always_comb begin
		next_rtsN = rtsN;
		unique case (rtsMode)
			RTS_TX_AUTO: next_rtsN = !txBusy;
			RTS_RX_FLOW: begin
				if (shadowCount >= SHADOW_THRESH) begin
					next_rtsN = 1'b1;
				end else if (shadowEmpty) begin
					next_rtsN = 1'b0;
				end
			end
			RTS_FORCE: next_rtsN = flowLine;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rtsN <= 1'b1;
		end else begin
			rtsN <= next_rtsN;
		end
	end

	// baud divider runs straight from the crystal
	baud_divider baudGen (
		.mclk(mclk),
		.reset_n(reset_n),
		.divisor({baudHigh, baudLow}),
		.enhanced(cfgFour[CFG4_ENHANCED]),
		.tick(baudTick)
	);

	// core and timer clock enables, quarter rate when selected and, for the timer, master clock enabled
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			quarterCnt <= 2'h0;
			coreTick <= 1'b0;
			timerTick <= 1'b0;
		end else begin
			quarterCnt <= quarterCnt + 2'h1;
			coreTick <= !quarter || quarterCnt == QUARTER_LAST;
			if (masterClock) begin
				timerTick <= !quarter || quarterCnt == QUARTER_LAST;
			end else begin
				timerTick <= baudTick;
			end
		end
	end

	// one-shot timer restarted by each timer_setting write
	assign target = timerTarget(mode[MODE_RES_SEL], timerSetting[TIMER_VALUE_LSB +: TIMER_VALUE_W]);
	assign timerHit = timerRun && timerTick && timerCount == target - 1'b1;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timerCount <= '0;
			timerRun <= 1'b0;
			timerExpired <= 1'b0;
		end else begin
			timerExpired <= timerHit;
			if (regWrite && regAddr == ADDR_TIMER) begin
				timerCount <= '0;
				timerRun <= 1'b1;
			end else if (timerHit) begin
				timerCount <= '0;
				timerRun <= 1'b0;
			end else if (timerRun && timerTick) begin
				timerCount <= timerCount + 1'b1;
			end
		end
	end

	// sticky status, a new event beats the read that clears it
	assign statusRead = regRead && regAddr == ADDR_STATUS;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timerDone <= 1'b0;
			overflow <= 1'b0;
		end else begin
			timerDone <= timerHit || (timerDone && !statusRead);
			overflow <= (rxTake && shadowFull && !(dropFlow && isFlow)) || (overflow && !statusRead);
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				ADDR_MODE: regRdData <= mode;
				ADDR_TIMER: regRdData <= timerSetting;
				ADDR_RXFC: regRdData <= rxFifoControl;
				ADDR_CFG4: regRdData <= cfgFour;
				ADDR_CFG0: regRdData <= cfgZero;
				ADDR_BAUD_LO: regRdData <= baudLow;
				ADDR_BAUD_HI: regRdData <= {6'h00, baudHigh};
				ADDR_XON: regRdData <= xonChar;
				ADDR_XOFF: regRdData <= xoffChar;
				ADDR_RXDATA: regRdData <= userEmpty ? 8'h00 : userHead;
				ADDR_STATUS: regRdData <= {overflow, timerDone, userEmpty, shadowEmpty,
					xonState, txEnable, ctsN, rtsN};
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	// checks
	AST_CTS_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
		(boundary && asyncMode && !ignoreCts && !inband && ctsN) |=> !txEnable)
		else $error("transmitter not stopped by high cts");

	AST_IGNORE_CTS: assert property (@(posedge mclk) disable iff (!reset_n)
		(boundary && asyncMode && ignoreCts && inband && !xonState) |=> !txEnable)
		else $error("xoff did not gate transmitter with cts ignored");

	AST_XON_RUN: assert property (@(posedge mclk) disable iff (!reset_n)
		(boundary && inband && xonState) |=> txEnable)
		else $error("xon state did not enable transmitter");

	AST_MID_CHAR: assert property (@(posedge mclk) disable iff (!reset_n)
		(txBusy && !txCharDone) |=> $stable(txEnable))
		else $error("transmit permission changed inside a character");

	AST_RTS_FULL: assert property (@(posedge mclk) disable iff (!reset_n)
		(rtsMode == RTS_RX_FLOW && shadowCount >= SHADOW_THRESH) |=> rtsN)
		else $error("rts not raised at shadow threshold");

	AST_RTS_EMPTY: assert property (@(posedge mclk) disable iff (!reset_n)
		(rtsMode == RTS_RX_FLOW && shadowEmpty) |=> !rtsN)
		else $error("rts not lowered on empty shadow");

	AST_RTS_AUTO: assert property (@(posedge mclk) disable iff (!reset_n)
		(rtsMode == RTS_TX_AUTO && txBusy) |=> !rtsN)
		else $error("rts not low during transmission");

	AST_RTS_FORCE: assert property (@(posedge mclk) disable iff (!reset_n)
		(asyncMode && forceLine) |=> (rtsN == $past(flowLine)))
		else $error("forced rts level wrong");

	AST_MOVE: assert property (@(posedge mclk) disable iff (!reset_n)
		(!shadowEmpty && !userFull) |=> (userCount != $past(userCount)) || $past(userPop))
		else $error("shadow byte not moved while room exists");

	AST_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
		(rxTake && dropFlow && isFlow) |=> shadowCount <= $past(shadowCount))
		else $error("flow character stored despite drop bit");

	AST_QUARTER: assert property (@(posedge mclk) disable iff (!reset_n)
		quarter ##1 (coreTick && quarter) ##1 quarter[*3] |-> !$past(coreTick) && !$past(coreTick, 2))
		else $error("core tick faster than one in four");

	AST_TIMER_LEN: assert property (@(posedge mclk) disable iff (!reset_n)
		timerExpired |-> ($past(timerCount) + 1'b1) == TIMER_W'(($past(mode[MODE_RES_SEL]) ? RES_FAST : RES_SLOW)
		* (int'($past(timerSetting[TIMER_VALUE_LSB +: TIMER_VALUE_W])) + 1)))
		else $error("timer expired at wrong count");
endmodule

//--- verilog/flow_baud_pkg.sv
// constants, register map and field layout for the flow and baud block
package flow_baud_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_TIMER = 4'h1;
	localparam logic [3:0] ADDR_RXFC = 4'h2;
	localparam logic [3:0] ADDR_CFG4 = 4'h3;
	localparam logic [3:0] ADDR_CFG0 = 4'h4;
	localparam logic [3:0] ADDR_BAUD_LO = 4'h5;
	localparam logic [3:0] ADDR_BAUD_HI = 4'h6;
	localparam logic [3:0] ADDR_XON = 4'h7;
	localparam logic [3:0] ADDR_XOFF = 4'h8;
	localparam logic [3:0] ADDR_RXDATA = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'ha;
	// async_mode_control fields
	localparam int MODE_FLOW_LINE = 6;
	localparam int MODE_IGNORE_CTS = 5;
	localparam int MODE_INBAND = 4;
	localparam int MODE_RX_ACTIVE = 3;
	localparam int MODE_FORCE = 2;
	localparam int MODE_RES_SEL = 1;
	localparam int MODE_LOOP = 0;
	// rx_fifo_control, channel_config_four, channel_config_zero fields
	localparam int RFC_DROP = 5;
	localparam int CFG4_QUARTER = 7;
	localparam int CFG4_ENHANCED = 6;
	localparam int CFG0_MCE = 7;
	localparam int CFG0_PROTO_LSB = 0;
	localparam int PROTO_W = 2;
	localparam logic [PROTO_W-1:0] PROTO_ASYNC = 2'h1;
	localparam int BAUD_HI_W = 2;
	// timer_setting fields
	localparam int TIMER_VALUE_LSB = 0;
	localparam int TIMER_VALUE_W = 5;
	localparam int TIMER_W = 21;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] XON_RESET = 8'h11;
	localparam logic [7:0] XOFF_RESET = 8'h13;
	// receive buffering
	localparam int FIFO_AW = 5;
	localparam int FIFO_DEPTH = 32;
	localparam logic [FIFO_AW:0] SHADOW_THRESH = 6'h1c;
	// clock quarter and baud divider
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam logic [3:0] STD_EXP = 4'h1;
	localparam int BAUD_N_W = 6;
	localparam int BAUD_POST_W = 15;
	// owner of the request line
	typedef enum {RTS_TX_AUTO, RTS_RX_FLOW, RTS_FORCE} rts_mode_e;
endpackage

//--- verilog/sync_fifo.sv
// small first-in first-out memory with registered head word
`timescale 1ns/100ps
module sync_fifo import flow_baud_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic push,
	input wire logic [7:0] wrData,
	input wire logic pop,
	output logic [7:0] rdData,
	output logic [FIFO_AW:0] count,
	output logic empty,
	output logic full
);
	logic [7:0] mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] wrPtr;
	logic [FIFO_AW-1:0] rdPtr;
	logic [FIFO_AW-1:0] next_rdPtr;

	assign empty = (count == '0);
	assign full = (count == (FIFO_AW+1)'(FIFO_DEPTH));
	assign next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;

	// storage, no reset needed
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= wrData;
		end
	end

	// pointers and fill level
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= push ? wrPtr + 1'b1 : wrPtr;
			rdPtr <= next_rdPtr;
			count <= count + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
		end
	end

	// head word, bypassing a write into the new head slot
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdData <= 8'h00;
		end else if (push && wrPtr == next_rdPtr) begin
			rdData <= wrData;
		end else begin
			rdData <= mem[next_rdPtr];
		end
	end
endmodule

//--- verilog/baud_divider.sv
// two-stage crystal divider producing one tick per baud clock
`timescale 1ns/100ps
module baud_divider import flow_baud_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [9:0] divisor,
	input wire logic enhanced,
	output logic tick
);
	logic [9:0] preCount;
	logic [BAUD_POST_W-1:0] postCount;
	logic [9:0] limit;
	logic [3:0] expo;
	logic [BAUD_POST_W-1:0] mask;
	logic preTick;

	// standard: (n+1)*2, enhanced: (n+1)*2^m
	assign limit = enhanced ? {4'h0, divisor[BAUD_N_W-1:0]} : divisor;
	assign expo = enhanced ? divisor[9:BAUD_N_W] : STD_EXP;
	assign mask = BAUD_POST_W'((16'h0001 << expo) - 16'h0001);
	assign preTick = (preCount >= limit);

	// first stage integer divide
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			preCount <= '0;
		end else begin
			preCount <= preTick ? '0 : preCount + 1'b1;
		end
	end

	// second stage power-of-two divide
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			postCount <= '0;
			tick <= 1'b0;
		end else begin
			postCount <= preTick ? postCount + 1'b1 : postCount;
			tick <= preTick && ((postCount & mask) == mask);
		end
	end
endmodule

//--- verification/remote_dte.sv
// remote terminal model: sends a byte burst and obeys our request line
`timescale 1ns/100ps
module remote_dte #(
	parameter int GAP = 1,
	parameter int LAG = 1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic rtsN,
	input wire logic go,
	input wire logic [7:0] count,
	input wire logic [7:0] base,
	output logic rxValid,
	output logic [7:0] rxByte
);
	logic [7:0] left;
	logic [7:0] nxt;
	int extra;
	int w;
	// burst sender, halts after LAG more bytes once rts goes high
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rxValid <= 1'b0;
			rxByte <= 8'h00;
			left <= 8'h00;
			nxt <= 8'h00;
			extra <= 0;
			w <= 0;
		end else begin
			rxValid <= 1'b0;
			rxByte <= ~rxByte; // line not held between strobes
			if (!rtsN) begin
				extra <= 0;
			end
			if (go) begin
				left <= count;
				nxt <= base;
				w <= 0;
			end else if (w != 0) begin
				w <= w - 1;
			end else if (left != 8'h00 && (!rtsN || extra < LAG)) begin
				rxValid <= 1'b1;
				rxByte <= nxt;
				nxt <= nxt + 8'h01;
				left <= left - 8'h01;
				w <= GAP - 1;
				if (rtsN) begin
					extra <= extra + 1;
				end
			end
		end
	end
endmodule

//--- verification/flow_baud_channel_tb.sv
// self-checking bench for the async flow and baud channel
`timescale 1ns/100ps
module flow_baud_channel_tb import flow_baud_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic ctsN = 1'b0;
	logic txBusy = 1'b0;
	logic txCharDone = 1'b0;
	logic go = 1'b0;
	logic [7:0] count = 8'h00;
	logic [7:0] base = 8'h00;
	logic [7:0] regRdData;
	logic [7:0] rxByte;
	logic rtsN, txEnable, rxValid, rxEnable, loopTest, coreTick, timerTick, baudTick, timerExpired;
	int miscompares = 0;
	int cmpCount = 0;
	int cyc = 0;
	// design with shortened timer factors
	flow_baud_channel #(.RES_SLOW(64), .RES_FAST(4)) dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .ctsN(ctsN),
		.rtsN(rtsN), .txBusy(txBusy), .txCharDone(txCharDone), .txEnable(txEnable), .rxValid(rxValid),
		.rxByte(rxByte), .rxEnable(rxEnable), .loopTest(loopTest), .coreTick(coreTick), .timerTick(timerTick),
		.baudTick(baudTick), .timerExpired(timerExpired));
	remote_dte far (.mclk(mclk), .reset_n(reset_n), .rtsN(rtsN), .go(go), .count(count), .base(base),
		.rxValid(rxValid), .rxByte(rxByte));
	// 25 MHz clock and hang guard
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compares=%0d miscompares=%0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmpCount++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic send(input logic [7:0] b, input int c);
		@(posedge mclk);
		base <= b;
		count <= 8'(c);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (3 * c + 8) @(posedge mclk);
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? baudTick : (s == 1 ? coreTick : timerTick);
	endfunction
	task automatic per(input int s, input int exp);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (pick(s) !== 1'b1 && n < 3000);
		end
		chk(8'(n), 8'(exp));
	endtask
	task automatic tmeas(input logic [7:0] v, output int n);
		wr(ADDR_TIMER, v);
		n = 0;
		while (timerExpired !== 1'b1 && n < 9000) begin
			@(posedge mclk);
			if (timerTick === 1'b1) n++;
		end
	endtask
	// reset values, a read-write place and an unmapped index
	task automatic t_reset();
		logic [3:0] ra [7] = '{ADDR_MODE, ADDR_RXFC, ADDR_CFG4, ADDR_CFG0, ADDR_XON, ADDR_XOFF, 4'hb};
		logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, XON_RESET, XOFF_RESET, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		wr(ADDR_MODE, 8'h5b);
		wr(4'hb, 8'hff);
		rd(ADDR_MODE, d);
		chk(d, 8'h5b);
		chkb(rxEnable, 1'b1);
		chkb(loopTest, 1'b1);
		rd(4'hb, d);
		chk(d, 8'h00);
	endtask
	// transmitter gating by cts, character boundary, rts owners
	task automatic t_cts();
		@(posedge mclk);
		ctsN <= 1'b1;
		wr(ADDR_CFG0, 8'h00);
		wr(ADDR_MODE, 8'h40);
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b1);
		wr(ADDR_CFG0, 8'h01);
		wr(ADDR_MODE, 8'h00);
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b0);
		ctsN <= 1'b0;
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b1);
		txBusy <= 1'b1;
		ctsN <= 1'b1;
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b1);
		chkb(rtsN, 1'b0);
		txCharDone <= 1'b1;
		txBusy <= 1'b0;
		@(posedge mclk);
		txCharDone <= 1'b0;
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b0);
		chkb(rtsN, 1'b1);
		wr(ADDR_MODE, 8'h20);
		repeat (3) @(posedge mclk);
		chkb(txEnable, 1'b1);
		wr(ADDR_MODE, 8'h04);
		repeat (2) @(posedge mclk);
		chkb(rtsN, 1'b0);
		wr(ADDR_MODE, 8'h44);
		repeat (2) @(posedge mclk);
		chkb(rtsN, 1'b1);
	endtask
	// flow characters dropped or kept, xon and xoff gating
	task automatic t_drop();
		logic [7:0] d;
		wr(ADDR_MODE, 8'h3c);
		wr(ADDR_RXFC, 8'h20);
		send(8'h11, 3);
		rd(ADDR_RXDATA, d);
		chk(d, 8'h12);
		rd(ADDR_RXDATA, d);
		chk(d, 8'h00);
		chkb(txEnable, 1'b0);
		wr(ADDR_RXFC, 8'h00);
		send(8'h10, 4);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_RXDATA, d);
			chk(d, 8'(8'h10 + i));
		end
		send(8'h11, 1);
		chkb(txEnable, 1'b1);
		rd(ADDR_RXDATA, d);
	endtask
	// shadow threshold raises rts, draining lowers it, order kept
	task automatic t_rx_flow();
		logic [7:0] d;
		wr(ADDR_MODE, 8'h48);
		repeat (2) @(posedge mclk);
		chkb(rtsN, 1'b0);
		send(8'h20, 70);
		chkb(rtsN, 1'b1);
		for (int i = 0; i < 70; i++) begin
			rd(ADDR_RXDATA, d);
			chk(d, 8'(8'h20 + i));
		end
		chkb(rtsN, 1'b0);
		rd(ADDR_STATUS, d);
		chk(d & 8'hb0, 8'h30);
		// rts forced low, both fifos fill and the shadow overruns, sticky overflow then cleared by read
		wr(ADDR_MODE, 8'h0c);
		send(8'h00, 70);
		rd(ADDR_STATUS, d);
		chk(d & 8'h80, 8'h80);
		rd(ADDR_STATUS, d);
		chk(d & 8'h80, 8'h00);
	endtask
	// quarter clock, timer clock source and both divider modes
	task automatic t_clocks();
		wr(ADDR_BAUD_LO, 8'h02);
		wr(ADDR_BAUD_HI, 8'h00);
		wr(ADDR_CFG4, 8'h00);
		per(0, 6);
		per(1, 1);
		per(2, 6);
		wr(ADDR_CFG4, 8'h80);
		per(1, 4);
		per(0, 6);
		per(2, 6);
		wr(ADDR_CFG0, 8'h81);
		per(2, 4);
		wr(ADDR_CFG4, 8'h40);
		per(2, 1);
		wr(ADDR_BAUD_LO, 8'h81);
		per(0, 8);
		wr(ADDR_BAUD_LO, 8'h3f);
		per(0, 64);
		wr(ADDR_BAUD_LO, 8'hc0);
		wr(ADDR_BAUD_HI, 8'h01);
		per(0, 128);
	endtask
	// timer length from resolution and value
	task automatic t_timer();
		int a;
		int b;
		wr(ADDR_MODE, 8'h02);
		tmeas(8'h02, a);
		tmeas(8'h05, b);
		chk(8'(b - a), 8'h0c);
		wr(ADDR_MODE, 8'h00);
		tmeas(8'h00, b);
		wr(ADDR_MODE, 8'h02);
		tmeas(8'h00, a);
		chk(8'(b - a), 8'h3c);
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge mclk);
		chkb(rtsN, 1'b1);
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset();
		t_cts();
		t_drop();
		t_rx_flow();
		t_clocks();
		t_timer();
		stop_test();
	end
endmodule
